// file: pkg/hfc_pkg.sv
package hfc_pkg;

  // Register map, system register space
  localparam logic [7:0] HFC_OSC_CTRL_ADDR  = 8'hb2;
  localparam logic [7:0] HFC_OSC_CTRL_RESET = 8'hc0;
  localparam logic [7:0] HFC_OSC_CTRL_WMASK = 8'ha3;
  localparam int         HFC_OSC_EN_BIT     = 7;
  localparam int         HFC_READY_BIT      = 6;
  localparam int         HFC_SUSPEND_BIT    = 5;
  localparam int         HFC_DIV_LSB        = 0;
  localparam int         HFC_DIV_W          = 2;

  // Register map, USB register space
  localparam logic [7:0] HFC_REC_CTRL_ADDR  = 8'h0f;
  localparam logic [7:0] HFC_REC_CTRL_RESET = 8'h0f;
  localparam int         HFC_REC_EN_BIT     = 7;
  localparam int         HFC_REC_SS_BIT     = 6;
  localparam int         HFC_REC_LOW_BIT    = 5;

  // Post-divider
  localparam int         HFC_PREDIV         = 4;
  localparam int         HFC_DIV_MAX        = 8;

  // USB clock source codes on the clock source select field
  localparam logic [1:0] HFC_USB_SRC_OSC      = 2'h0;
  localparam logic [1:0] HFC_USB_SRC_OSC_DIV8 = 2'h1;
  localparam logic [1:0] HFC_USB_SRC_EXT      = 2'h2;
  localparam logic [1:0] HFC_USB_SRC_EXT_DIV  = 2'h3;

  // Timing at the 10 MHz register clock
  localparam int         HFC_CLK_PERIOD_NS  = 100;
  localparam int         HFC_SETTLE_NS      = 2000;
  localparam int         HFC_SETTLE_CYC     = (HFC_SETTLE_NS + HFC_CLK_PERIOD_NS - 1) / HFC_CLK_PERIOD_NS;
  localparam int         HFC_FRAME_US       = 1000;
  localparam int         HFC_FRAME_CYC      = HFC_FRAME_US * 1000 / HFC_CLK_PERIOD_NS;

  // Recovery trim
  localparam logic [7:0] HFC_TRIM_RESET     = 8'h80;
  localparam int         HFC_BAND_FS        = 2;
  localparam int         HFC_BAND_LS        = 8;
  localparam int         HFC_STEP_SHIFT     = 3;

  typedef enum logic [1:0] {
    HFC_DIV8 = 2'h0,
    HFC_DIV4 = 2'h1,
    HFC_DIV2 = 2'h2,
    HFC_DIV1 = 2'h3
  } hfc_div_t;

  // One register access on either register space
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } hfc_reg_req_t;

  // Recovery settings handed to the trim engine
  typedef struct packed {
    logic enable;
    logic single_step;
    logic low_speed;
  } hfc_rec_cfg_t;

endpackage

// file: core/hfc_clk_recovery.sv
`timescale 1ns/10ps
`default_nettype none

module hfc_clk_recovery
  import hfc_pkg::*;
#(
  parameter int FRAME_CYC = HFC_FRAME_CYC
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire hfc_rec_cfg_t cfg,
  input  wire logic         osc_running,
  input  wire logic         usb_sof,
  output logic [7:0]        trim,
  output logic              locked
);

  localparam int CW = $clog2(FRAME_CYC * 2 + 1) + 1;

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          seen;
  logic          next_seen;
  logic [7:0]    next_trim;
  logic          next_locked;
  logic [CW:0]   err;
  logic [CW:0]   mag;
  logic [CW:0]   band;
  logic [CW:0]   step;

  // Frame measurement and trim update on each frame marker
  always_comb begin
    next_count  = count;
    next_seen   = seen;
    next_trim   = trim;
    next_locked = locked;
    err  = {1'b0, count} - (CW + 1)'(FRAME_CYC);
    mag  = err[CW] ? -err : err;
    band = cfg.low_speed ? (CW + 1)'(HFC_BAND_LS) : (CW + 1)'(HFC_BAND_FS);
    step = cfg.single_step ? (CW + 1)'(1) : (mag >> HFC_STEP_SHIFT);
    if (step == '0) begin
      step = (CW + 1)'(1);
    end
    if (step > (CW + 1)'(16)) begin
      step = (CW + 1)'(16);
    end
    if (!cfg.enable || !osc_running) begin
      // Lose the frame phase; first marker after enable only restarts
      next_count  = '0;
      next_seen   = 1'b0;
      next_locked = 1'b0;
    end else if (usb_sof) begin
      // Marker cycle is the first of the new frame, so count equals frame length
      next_count = CW'(1);
      next_seen  = 1'b1;
      if (seen) begin
        if (mag <= band) begin
          next_locked = 1'b1;
        end else begin
          next_locked = 1'b0;
          if (!err[CW]) begin
            // Too many ticks per frame: oscillator fast
            next_trim = (trim < step[7:0]) ? 8'h00 : trim - step[7:0];
          end else begin
            next_trim = (8'hff - trim < step[7:0]) ? 8'hff : trim + step[7:0];
          end
        end
      end
    end else if (count != {CW{1'b1}}) begin
      next_count = count + CW'(1);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count  <= '0;
      seen   <= 1'b0;
      trim   <= HFC_TRIM_RESET;
      locked <= 1'b0;
    end else begin
      count  <= next_count;
      seen   <= next_seen;
      trim   <= next_trim;
      locked <= next_locked;
    end
  end

endmodule

`default_nettype wire

// file: core/hfc_osc_ctrl.sv
// Notes on behaviour
// - Oscillator runs while enable bit 7 is set; it resets to 1.
// - Bit 6 is read-only, high only while oscillator runs at programmed frequency.
// - Writing 1 to suspend bit 5 halts oscillator and enters suspend.
// - In suspend, any wake-up event restarts the oscillator.
// - Oscillator output passes a fixed divide-by-4, then the bits 1:0 divider.
// - Divider codes 00,01,10,11 give divide by 8,4,2,1.
// - Bits 4:2 read zero; writes to them are ignored.
// - USB function runs full or low speed per transceiver speed bit.
// - USB clock comes from clock source select, independent of the divider.
// - With recovery active, oscillator trim follows incoming USB frame timing.
// - Recovery control bit 7 at USB address 0x0f enables recovery.
// - Recovery control bit 6 forces single-step calibration.
// - Recovery control bit 5 selects low-speed recovery.
`timescale 1ns/10ps
`default_nettype none

module hfc_osc_ctrl
  import hfc_pkg::*;
#(
  parameter int NUM_WAKE   = 4,
  parameter int SETTLE_CYC = HFC_SETTLE_CYC,
  parameter int FRAME_CYC  = HFC_FRAME_CYC
) (
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire hfc_reg_req_t        sfr,
  output logic [7:0]               sfr_rdata,
  output logic                     sfr_hit,
  input  wire hfc_reg_req_t        usb_reg,
  output logic [7:0]               usb_rdata,
  output logic                     usb_hit,
  input  wire logic [NUM_WAKE-1:0] wake_pins,
  input  wire logic                usb_sof,
  input  wire logic                usb_speed_full,
  input  wire logic [1:0]          clock_source_select,
  output logic                     osc_run,
  output logic [7:0]               osc_trim,
  output logic                     hf_osc_freq_ready,
  output logic                     suspended,
  output logic                     system_clock_tick,
  output logic [5:0]               system_clock_div,
  output logic [1:0]               usb_clk_src,
  output logic                     usb_clk_valid,
  output logic                     usb_full_speed,
  output logic                     recovery_active,
  output logic                     recovery_locked
);

  typedef enum logic [3:0] {
    ST_OFF   = 4'b0001,
    ST_START = 4'b0010,
    ST_RUN   = 4'b0100,
    ST_SUSP  = 4'b1000
  } hfc_state_t;

  localparam int SW = $clog2(SETTLE_CYC + 1);

  hfc_state_t         state;
  hfc_state_t         next_state;
  logic [SW-1:0]      settle;
  logic [SW-1:0]      next_settle;
  logic               hf_osc_enable;
  logic               next_hf_osc_enable;
  hfc_div_t           hf_osc_divider_sel;
  hfc_div_t           next_hf_osc_divider_sel;
  logic [7:0]         recovery_control;
  logic [7:0]         next_recovery_control;
  logic [NUM_WAKE-1:0] wake_meta;
  logic [NUM_WAKE-1:0] wake_sync;
  logic               wake_any;
  logic               osc_wr;
  logic               rec_wr;
  logic               suspend_req;
  logic [7:0]         osc_view;
  logic [7:0]         next_sfr_rdata;
  logic               next_sfr_hit;
  logic [7:0]         next_usb_rdata;
  logic               next_usb_hit;
  logic [5:0]         div_cnt;
  logic [5:0]         next_div_cnt;
  logic [5:0]         next_system_clock_div;
  logic               next_system_clock_tick;
  logic [1:0]         next_usb_clk_src;
  logic               next_usb_clk_valid;
  logic               next_usb_full_speed;
  logic               usb_from_osc;
  hfc_rec_cfg_t       rec_cfg;

  // Wake pins come from outside the clock domain: two flops before use
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wake_meta <= '0;
      wake_sync <= '0;
    end else begin
      wake_meta <= wake_pins;
      wake_sync <= wake_meta;
    end
  end

  assign wake_any    = |wake_sync;
  assign osc_wr      = sfr.wr && (sfr.addr == HFC_OSC_CTRL_ADDR);
  assign rec_wr      = usb_reg.wr && (usb_reg.addr == HFC_REC_CTRL_ADDR);
  assign suspend_req = osc_wr && sfr.wdata[HFC_SUSPEND_BIT];

  // Register view; ready and suspend show live state, 4:2 read as zero
  always_comb begin
    osc_view                  = 8'h00;
    osc_view[HFC_OSC_EN_BIT]  = hf_osc_enable;
    osc_view[HFC_READY_BIT]   = (state == ST_RUN);
    osc_view[HFC_SUSPEND_BIT] = (state == ST_SUSP);
    osc_view[HFC_DIV_LSB +: HFC_DIV_W] = hf_osc_divider_sel;
  end

  // Control register writes
  always_comb begin
    next_hf_osc_enable      = hf_osc_enable;
    next_hf_osc_divider_sel = hf_osc_divider_sel;
    next_recovery_control   = recovery_control;
    if (osc_wr) begin
      // Ready, suspend and the unused bits are not stored
      next_hf_osc_enable      = sfr.wdata[HFC_OSC_EN_BIT];
      next_hf_osc_divider_sel = hfc_div_t'(sfr.wdata[HFC_DIV_LSB +: HFC_DIV_W]);
    end
    if (rec_wr) begin
      // Low five bits kept as written so software sees its own value
      next_recovery_control = usb_reg.wdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hf_osc_enable      <= HFC_OSC_CTRL_RESET[HFC_OSC_EN_BIT];
      hf_osc_divider_sel <= hfc_div_t'(HFC_OSC_CTRL_RESET[HFC_DIV_LSB +: HFC_DIV_W]);
      recovery_control   <= HFC_REC_CTRL_RESET;
    end else begin
      hf_osc_enable      <= next_hf_osc_enable;
      hf_osc_divider_sel <= next_hf_osc_divider_sel;
      recovery_control   <= next_recovery_control;
    end
  end

  // Oscillator state; reset leaves it running and ready
  always_comb begin
    next_state  = state;
    next_settle = settle;
    unique case (state)
      ST_OFF: begin
        if (next_hf_osc_enable) begin
          next_state  = ST_START;
          next_settle = '0;
        end
      end
      ST_START: begin
        if (!next_hf_osc_enable) begin
          next_state = ST_OFF;
        end else if (suspend_req) begin
          next_state = ST_SUSP;
        end else if (settle == SW'(SETTLE_CYC - 1)) begin
          next_state = ST_RUN;
        end else begin
          next_settle = settle + SW'(1);
        end
      end
      ST_RUN: begin
        if (!next_hf_osc_enable) begin
          next_state = ST_OFF;
        end else if (suspend_req) begin
          next_state = ST_SUSP;
        end
      end
      ST_SUSP: begin
        if (!next_hf_osc_enable) begin
          next_state = ST_OFF;
        end else if (wake_any) begin
          // Restart goes through settling, so ready lags the wake
          next_state  = ST_START;
          next_settle = '0;
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state  <= ST_RUN;
      settle <= '0;
    end else begin
      state  <= next_state;
      settle <= next_settle;
    end
  end

  assign osc_run           = (state == ST_START) || (state == ST_RUN);
  assign hf_osc_freq_ready = (state == ST_RUN);
  assign suspended         = (state == ST_SUSP);

  // System clock post-divider model: one tick per divided period
  always_comb begin
    next_system_clock_div  = 6'(HFC_PREDIV * (HFC_DIV_MAX >> hf_osc_divider_sel));
    next_div_cnt           = div_cnt;
    next_system_clock_tick = 1'b0;
    if (!osc_run) begin
      // No oscillator edges, so no ticks
      next_div_cnt = '0;
    end else if (div_cnt >= system_clock_div - 6'(1)) begin
      next_div_cnt           = '0;
      next_system_clock_tick = 1'b1;
    end else begin
      next_div_cnt = div_cnt + 6'(1);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_cnt           <= '0;
      system_clock_div  <= 6'(HFC_PREDIV * HFC_DIV_MAX);
      system_clock_tick <= 1'b0;
    end else begin
      div_cnt           <= next_div_cnt;
      system_clock_div  <= next_system_clock_div;
      system_clock_tick <= next_system_clock_tick;
    end
  end

  // USB clock routing, apart from the system divider
  assign usb_from_osc = (clock_source_select == HFC_USB_SRC_OSC) ||
                        (clock_source_select == HFC_USB_SRC_OSC_DIV8);

  always_comb begin
    next_usb_clk_src    = clock_source_select;
    next_usb_full_speed = usb_speed_full;
    // An oscillator-sourced USB clock is only good while it runs
    next_usb_clk_valid  = usb_from_osc ? osc_run : 1'b1;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      usb_clk_src    <= HFC_USB_SRC_OSC;
      usb_clk_valid  <= 1'b1;
      usb_full_speed <= 1'b0;
    end else begin
      usb_clk_src    <= next_usb_clk_src;
      usb_clk_valid  <= next_usb_clk_valid;
      usb_full_speed <= next_usb_full_speed;
    end
  end

  // Recovery trims only an oscillator that feeds the USB clock
  always_comb begin
    rec_cfg.enable      = recovery_control[HFC_REC_EN_BIT] && usb_from_osc;
    rec_cfg.single_step = recovery_control[HFC_REC_SS_BIT];
    rec_cfg.low_speed   = recovery_control[HFC_REC_LOW_BIT];
  end

  assign recovery_active = rec_cfg.enable && osc_run;

  hfc_clk_recovery #(
    .FRAME_CYC (FRAME_CYC)
  ) u_recovery (
    .clock       (clock),
    .rst         (rst),
    .cfg         (rec_cfg),
    .osc_running (osc_run),
    .usb_sof     (usb_sof),
    .trim        (osc_trim),
    .locked      (recovery_locked)
  );

  // Read data registered; unmapped addresses read zero with no hit
  always_comb begin
    next_sfr_rdata = sfr_rdata;
    next_sfr_hit   = 1'b0;
    next_usb_rdata = usb_rdata;
    next_usb_hit   = 1'b0;
    if (sfr.rd) begin
      next_sfr_hit   = (sfr.addr == HFC_OSC_CTRL_ADDR);
      next_sfr_rdata = next_sfr_hit ? osc_view : 8'h00;
    end
    if (usb_reg.rd) begin
      next_usb_hit   = (usb_reg.addr == HFC_REC_CTRL_ADDR);
      next_usb_rdata = next_usb_hit ? recovery_control : 8'h00;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
      sfr_hit   <= 1'b0;
      usb_rdata <= 8'h00;
      usb_hit   <= 1'b0;
    end else begin
      sfr_rdata <= next_sfr_rdata;
      sfr_hit   <= next_sfr_hit;
      usb_rdata <= next_usb_rdata;
      usb_hit   <= next_usb_hit;
    end
  end

endmodule

`default_nettype wire

// file: sim/hfc_osc_ctrl_chk.sv
`timescale 1ns/10ps
`default_nettype none

module hfc_osc_ctrl_chk
  import hfc_pkg::*;
#(
  parameter int NUM_WAKE   = 4,
  parameter int SETTLE_CYC = HFC_SETTLE_CYC
) (
  input wire logic                clock,
  input wire logic                rst,
  input wire hfc_reg_req_t        sfr,
  input wire logic [7:0]          sfr_rdata,
  input wire logic                sfr_hit,
  input wire hfc_reg_req_t        usb_reg,
  input wire logic                usb_hit,
  input wire logic [NUM_WAKE-1:0] wake_pins,
  input wire logic                osc_run,
  input wire logic                hf_osc_freq_ready,
  input wire logic                suspended,
  input wire logic                system_clock_tick,
  input wire logic [5:0]          system_clock_div,
  input wire logic                recovery_active,
  input wire logic [7:0]          osc_trim
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  logic [7:0] wait_cnt;
  logic [7:0] next_wait_cnt;
  wire logic  osc_wr = sfr.wr && sfr.addr == HFC_OSC_CTRL_ADDR;

  // Cycles spent running but not yet settled
  always_comb begin
    next_wait_cnt = (osc_run && !hf_osc_freq_ready) ? wait_cnt + 8'h01 : 8'h00;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wait_cnt <= 8'h00;
    end else begin
      wait_cnt <= next_wait_cnt;
    end
  end

  ready_needs_run_a: assert property (hf_osc_freq_ready |-> osc_run && !suspended)
    else $error("ready flag set while oscillator halted");
  suspend_halt_a: assert property (osc_wr && sfr.wdata[7] && sfr.wdata[5] && osc_run
    |=> suspended && !osc_run && !hf_osc_freq_ready) else $error("suspend write did not halt");
  enable_off_a: assert property (osc_wr && !sfr.wdata[7] |=> !osc_run && !hf_osc_freq_ready)
    else $error("disable write left oscillator running");
  wake_up_a: assert property (suspended && (|wake_pins) |-> ##[1:4] osc_run)
    else $error("wake event did not restart oscillator");
  settle_max_a: assert property (wait_cnt <= 8'(SETTLE_CYC + 2))
    else $error("ready flag late after restart");
  settle_min_a: assert property ($rose(hf_osc_freq_ready) |-> wait_cnt >= 8'(SETTLE_CYC - 2))
    else $error("ready flag early after restart");
  div_take_a: assert property (osc_wr |-> ##2 system_clock_div == (6'h20 >> $past(sfr.wdata[1:0], 2)))
    else $error("system clock divide wrong");
  tick_gap_a: assert property (system_clock_tick |=> !system_clock_tick [*3])
    else $error("system clock ticks too close");
  read_view_a: assert property (sfr.rd && sfr.addr == HFC_OSC_CTRL_ADDR |=> sfr_hit
    && sfr_rdata[4:2] == 3'h0 && sfr_rdata[6] == $past(hf_osc_freq_ready)) else $error("control read wrong");
  rec_read_a: assert property (usb_reg.rd && usb_reg.addr == HFC_REC_CTRL_ADDR |=> usb_hit)
    else $error("recovery control read missed");
  rec_needs_osc_a: assert property (recovery_active |-> osc_run)
    else $error("recovery active without oscillator");
  trim_hold_a: assert property (!recovery_active |=> $stable(osc_trim))
    else $error("trim moved with recovery inactive");
endmodule

bind hfc_osc_ctrl hfc_osc_ctrl_chk #(.NUM_WAKE(NUM_WAKE), .SETTLE_CYC(SETTLE_CYC)) chk (
  .clock, .rst, .sfr, .sfr_rdata, .sfr_hit, .usb_reg, .usb_hit, .wake_pins, .osc_run,
  .hf_osc_freq_ready, .suspended, .system_clock_tick, .system_clock_div, .recovery_active, .osc_trim
);

`default_nettype wire

// file: sim/tb_hf_osc_and_usb_clock_config.sv
`timescale 1ns/10ps
`default_nettype none

module tb_hf_osc_and_usb_clock_config
  import hfc_pkg::*;
;
  logic         clock, rst, usb_sof, usb_speed_full, hit, ss;
  hfc_reg_req_t sfr, usb_reg;
  logic [3:0]   wake_pins;
  logic [1:0]   clock_source_select, usb_clk_src;
  logic [7:0]   sfr_rdata, usb_rdata, osc_trim, rd, v, trim_exp;
  logic [5:0]   sdiv;
  logic         sfr_hit, usb_hit, osc_run, ready, suspended, tick, clk_valid, full, rec_act, locked, lk_exp;
  int           num_errors = 0, cmp_count = 0, cyc = 0, last_sof, band, n;

  hfc_osc_ctrl #(.FRAME_CYC(100)) dut (
    .clock(clock), .rst(rst), .sfr(sfr), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .usb_reg(usb_reg), .usb_rdata(usb_rdata), .usb_hit(usb_hit), .wake_pins(wake_pins),
    .usb_sof(usb_sof), .usb_speed_full(usb_speed_full), .clock_source_select(clock_source_select),
    .osc_run(osc_run), .osc_trim(osc_trim), .hf_osc_freq_ready(ready), .suspended(suspended),
    .system_clock_tick(tick), .system_clock_div(sdiv), .usb_clk_src(usb_clk_src),
    .usb_clk_valid(clk_valid), .usb_full_speed(full), .recovery_active(rec_act), .recovery_locked(locked)
  );

  // 10 MHz clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Cycle count; the ceiling cuts a hang short
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One-cycle request, then a spare cycle so requests never abut
  task automatic acc(bit u, bit w, logic [7:0] a, logic [7:0] d);
    hfc_reg_req_t q;
    q = '{addr: a, wdata: d, wr: w, rd: !w};
    @(negedge clock);
    if (u) usb_reg = q;
    else sfr = q;
    @(negedge clock);
    sfr = '0;
    usb_reg = '0;
    rd = u ? usb_rdata : sfr_rdata;
    hit = u ? usb_hit : sfr_hit;
    @(negedge clock);
  endtask

  task automatic wait_ready();
    for (int i = 0; i < 60 && ready !== 1'b1; i++) @(negedge clock);
  endtask

  function automatic int step_of(int err);
    int m = err < 0 ? -err : err;
    m = m >> HFC_STEP_SHIFT;
    if (ss) return 1;
    return m < 1 ? 1 : (m > 16 ? 16 : m);
  endfunction

  // Frame markers p cycles apart; expected trim worked out per frame
  task automatic frames(int cnt, int p, bit on);
    int e;
    for (int i = 0; i < cnt; i++) begin
      while (cyc < last_sof + p - 1) @(negedge clock);
      usb_sof = 1'b1;
      @(negedge clock);
      usb_sof = 1'b0;
      last_sof = cyc;
      e = p - 100;
      if (on) begin
        lk_exp = (e <= band && e >= -band);
        if (!lk_exp) trim_exp = e > 0 ? trim_exp - 8'(step_of(e)) : trim_exp + 8'(step_of(e));
      end else begin
        // Recovery off or first marker: nothing locks
        lk_exp = 1'b0;
      end
    end
    repeat (3) @(negedge clock);
    chk("trim", trim_exp, osc_trim);
    chk("locked", 8'(lk_exp), 8'(locked));
  endtask

  initial begin
    rst = 1'b1;
    sfr = '0;
    usb_reg = '0;
    wake_pins = 4'h0;
    usb_sof = 1'b0;
    usb_speed_full = 1'b0;
    clock_source_select = 2'h0;
    v = 8'($urandom(32'h422ab6cb));
    repeat (8) @(negedge clock);
    rst = 1'b0;
    // Reset values and an unmapped place
    acc(0, 0, HFC_OSC_CTRL_ADDR, 8'h00);
    chk("osc_ctrl", HFC_OSC_CTRL_RESET, rd);
    acc(1, 0, HFC_REC_CTRL_ADDR, 8'h00);
    chk("rec_ctrl", 8'h0f, rd);
    chk("rec_hit", 8'h01, 8'(hit));
    acc(0, 1, 8'hb3, 8'h00);
    acc(0, 0, 8'hb3, 8'h00);
    chk("unmapped", 8'h00, {rd[7:1], hit});
    // Every divider code, junk in the read-only bits
    for (int c = 0; c < 4; c++) begin
      v = 8'h80 | (8'($urandom) & 8'h5c) | 8'(c);
      acc(0, 1, HFC_OSC_CTRL_ADDR, v);
      acc(0, 0, HFC_OSC_CTRL_ADDR, 8'h00);
      chk("osc_ctrl", 8'hc0 | 8'(c), rd);
      chk("sys_div", 8'(HFC_PREDIV * (8 >> c)), 8'(sdiv));
      for (n = 0; n < 100 && tick !== 1'b1; n++) @(negedge clock);
      @(negedge clock);
      for (n = 1; n < 100 && tick !== 1'b1; n++) @(negedge clock);
      chk("tick_gap", 8'(HFC_PREDIV * (8 >> c)), 8'(n));
    end
    // USB clock source and speed follow their controls
    for (int c = 0; c < 4; c++) begin
      clock_source_select = 2'(c);
      usb_speed_full = 1'($urandom);
      repeat (3) @(negedge clock);
      chk("usb_src", 8'(c), 8'(usb_clk_src));
      chk("usb_speed", 8'(usb_speed_full), 8'(full));
    end
    clock_source_select = 2'h0;
    // Disable, then restart and settle
    acc(0, 1, HFC_OSC_CTRL_ADDR, 8'h00);
    acc(0, 0, HFC_OSC_CTRL_ADDR, 8'h00);
    chk("osc_ctrl", 8'h00, rd);
    chk("usb_valid", 8'h00, 8'(clk_valid));
    acc(0, 1, HFC_OSC_CTRL_ADDR, 8'h83);
    acc(0, 0, HFC_OSC_CTRL_ADDR, 8'h00);
    chk("osc_ctrl", 8'h83, rd);
    wait_ready();
    acc(0, 0, HFC_OSC_CTRL_ADDR, 8'h00);
    chk("osc_ctrl", 8'hc3, rd);
    // Suspend, wake on a random pin
    acc(0, 1, HFC_OSC_CTRL_ADDR, 8'ha3);
    acc(0, 0, HFC_OSC_CTRL_ADDR, 8'h00);
    chk("osc_ctrl", 8'ha3, rd);
    wake_pins[$urandom_range(3, 0)] = 1'b1;
    wait_ready();
    wake_pins = 4'h0;
    acc(0, 0, HFC_OSC_CTRL_ADDR, 8'h00);
    chk("osc_ctrl", 8'hc3, rd);
    // Recovery: full speed, single step, low speed, off
    trim_exp = HFC_TRIM_RESET;
    lk_exp = 1'b0;
    ss = 1'b0;
    band = HFC_BAND_FS;
    usb_speed_full = 1'b1;
    clock_source_select = HFC_USB_SRC_OSC;
    acc(1, 1, HFC_REC_CTRL_ADDR, 8'h8f);
    acc(1, 0, HFC_REC_CTRL_ADDR, 8'h00);
    chk("rec_ctrl", 8'h8f, rd);
    chk("rec_active", 8'h01, 8'(rec_act));
    last_sof = cyc;
    frames(1, 1, 0);
    frames(2, 100, 1);
    frames(2, 110, 1);
    frames(2, 90, 1);
    frames(1, 103, 1);
    frames(1, 200, 1);
    acc(1, 1, HFC_REC_CTRL_ADDR, 8'hcf);
    ss = 1'b1;
    frames(1, 200, 1);
    clock_source_select = HFC_USB_SRC_OSC_DIV8;
    usb_speed_full = 1'b0;
    acc(1, 1, HFC_REC_CTRL_ADDR, 8'haf);
    ss = 1'b0;
    band = HFC_BAND_LS;
    frames(2, 106, 1);
    clock_source_select = HFC_USB_SRC_OSC;
    usb_speed_full = 1'b1;
    acc(1, 1, HFC_REC_CTRL_ADDR, 8'h8f);
    band = HFC_BAND_FS;
    frames(1, 106, 1);
    // An external USB clock leaves nothing to trim
    clock_source_select = HFC_USB_SRC_EXT;
    @(negedge clock);
    chk("rec_active", 8'h00, 8'(rec_act));
    clock_source_select = HFC_USB_SRC_OSC;
    acc(1, 1, HFC_REC_CTRL_ADDR, 8'h0f);
    chk("rec_active", 8'h00, 8'(rec_act));
    usb_speed_full = 1'b0;
    frames(2, 200, 0);
    // Second reset in mid-run
    rst = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    acc(0, 0, HFC_OSC_CTRL_ADDR, 8'h00);
    chk("osc_ctrl", HFC_OSC_CTRL_RESET, rd);
    chk("trim", HFC_TRIM_RESET, osc_trim);
    acc(1, 0, HFC_REC_CTRL_ADDR, 8'h00);
    chk("rec_ctrl", HFC_REC_CTRL_RESET, rd);
    conclude();
  end
endmodule

`default_nettype wire
